// ===== rtl/cwc_pkg.sv
// constants and types of the clear-watchdog and complement execute block
`default_nettype none
package cwc_pkg;

	localparam int DATA_W = 8;
	localparam int MEM_AW = 12;
	localparam int BUS_AW = 4;
	localparam int INSTR_W = 16;
	localparam int MEM_DEPTH = 4096;

	// instruction encodings
	localparam logic [15:0] CLEAR_WATCHDOG_WORD = 16'h0004;
	localparam logic [5:0] COMPLEMENT_PREFIX = 6'h07;
	localparam logic [6:0] ZERO_PREFIX = 7'h35;
	localparam int COMPLEMENT_PFX_LSB = 10;
	localparam int ZERO_PFX_LSB = 9;
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;

	// operand addressing
	localparam logic [7:0] INDEX_LIMIT = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT_STD = 8'h80;
	localparam logic [7:0] ACCESS_SPLIT_EXT = 8'h60;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

	// register offsets on the plain port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_BANK = 4'h1;
	localparam logic [3:0] REG_WORK = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_INDEX_LO = 4'h4;
	localparam logic [3:0] REG_INDEX_HI = 4'h5;
	localparam logic [3:0] REG_MEM_ADDR_LO = 4'h6;
	localparam logic [3:0] REG_MEM_ADDR_HI = 4'h7;
	localparam logic [3:0] REG_MEM_DATA = 4'h8;
	localparam logic [3:0] REG_CLEAR_COUNT = 4'h9;

	// field positions
	localparam int CTRL_EXT_BIT = 0;
	localparam int ST_ZERO = 0;
	localparam int ST_NEG = 1;
	localparam int ST_POWERDOWN = 2;
	localparam int ST_TIMEOUT = 3;
	localparam int STATUS_W = 4;

	// reset values
	localparam logic [3:0] STATUS_RST = 4'hC;
	localparam logic [3:0] BANK_RST = 4'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [11:0] ADDR_ZERO = 12'h000;

	typedef enum logic [1:0] {
		CWC_Q1 = 2'b00,
		CWC_Q2 = 2'b01,
		CWC_Q3 = 2'b10,
		CWC_Q4 = 2'b11
	} cwc_phase_e;

	typedef enum logic [1:0] {
		CWC_OP_NONE = 2'b00,
		CWC_OP_DOG  = 2'b01,
		CWC_OP_COMP = 2'b10,
		CWC_OP_ZERO = 2'b11
	} cwc_op_e;

endpackage : cwc_pkg
`default_nettype wire

// ===== rtl/cwc_mem_if.sv
// interface between the execute core and its data memory
`timescale 1ns/1ps
`default_nettype none
interface cwc_mem_if;
	import cwc_pkg::*;
	logic [MEM_AW-1:0] a_addr;
	logic [DATA_W-1:0] a_wdata;
	logic              a_we;
	logic [DATA_W-1:0] a_rdata;
	logic [MEM_AW-1:0] b_addr;
	logic [DATA_W-1:0] b_wdata;
	logic              b_we;
	logic [DATA_W-1:0] b_rdata;

	modport core (output a_addr, a_wdata, a_we, b_addr, b_wdata, b_we,
		input a_rdata, b_rdata);
	modport mem (input a_addr, a_wdata, a_we, b_addr, b_wdata, b_we,
		output a_rdata, b_rdata);
endinterface : cwc_mem_if
`default_nettype wire

// ===== rtl/cwc_data_mem.sv
// dual-port data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module cwc_data_mem #(
	parameter int DEPTH = cwc_pkg::MEM_DEPTH
) (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	cwc_mem_if.mem    mem
);
	import cwc_pkg::*;

	logic [DATA_W-1:0] store [DEPTH];
	logic              b_collide;

	// core port wins a same-address write
	assign b_collide = mem.a_we && (mem.a_addr == mem.b_addr);

	always_ff @(posedge clk_i) begin
		if (mem.a_we) begin
			store[mem.a_addr] <= mem.a_wdata;
		end
		if (mem.b_we && !b_collide) begin
			store[mem.b_addr] <= mem.b_wdata;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mem.a_rdata <= BYTE_ZERO;
			mem.b_rdata <= BYTE_ZERO;
		end else begin
			mem.a_rdata <= store[mem.a_addr];
			mem.b_rdata <= store[mem.b_addr];
		end
	end

endmodule : cwc_data_mem
`default_nettype wire

// ===== rtl/cwc_exec.sv
// execute logic for clear-watchdog, complement-register and zero-register
// Functional notes
// - Clear-watchdog zeroes the watchdog counter and postscaler and sets timeout and powerdown.
// - Complement reads the addressed register and forms its bitwise inverse.
// - With destination bit zero the inverse goes to the working register, source untouched.
// - With destination bit one the inverse is written back to the addressed register.
// - Bank bit zero addresses the access bank, bank bit one uses the bank select register.
// - Extended set on, bank bit zero and operand up to 5Fh selects indexed literal offset.
// - Zero-register forces the addressed register to zero, banked when the bank bit is one.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cwc_exec (
	input  wire logic                         clk_i,
	input  wire logic                         reset_n_i,
	input  wire logic [cwc_pkg::INSTR_W-1:0]  instr_word_i,
	input  wire logic                         instr_valid_i,
	input  wire logic [cwc_pkg::BUS_AW-1:0]   bus_addr_i,
	input  wire logic [cwc_pkg::DATA_W-1:0]   bus_wdata_i,
	input  wire logic                         bus_wr_i,
	input  wire logic                         bus_rd_i,
	output logic      [cwc_pkg::DATA_W-1:0]   bus_rdata_o,
	output logic      [1:0]                   phase_o,
	output logic                              watchdog_clear_o,
	output logic                              timeout_flag_o,
	output logic                              powerdown_flag_o,
	output logic      [cwc_pkg::DATA_W-1:0]   work_reg_o
);
	import cwc_pkg::*;

	cwc_mem_if mem_bus ();

	cwc_data_mem #(
		.DEPTH (MEM_DEPTH)
	) u_mem (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.mem       (mem_bus.mem)
	);

	cwc_phase_e          phase_reg;
	cwc_phase_e          phase_next;
	logic [INSTR_W-1:0]  instr_reg;
	logic [INSTR_W-1:0]  instr_next;
	logic [DATA_W-1:0]   result_reg;
	logic [DATA_W-1:0]   result_next;
	logic [DATA_W-1:0]   work_reg;
	logic [DATA_W-1:0]   work_next;
	logic [STATUS_W-1:0] status_reg;
	logic [STATUS_W-1:0] status_next;
	logic [3:0]          bank_select_reg;
	logic                ext_en_reg;
	logic [MEM_AW-1:0]   index_reg;
	logic [MEM_AW-1:0]   mem_addr_reg;
	logic [DATA_W-1:0]   watchdog_clears_reg;
	logic                dog_clear_reg;
	logic [DATA_W-1:0]   rdata_reg;
	logic [DATA_W-1:0]   rdata_next;

	cwc_op_e             op;
	logic [7:0]          operand;
	logic                bank_bit;
	logic                dest_bit;
	logic                indexed;
	logic [7:0]          access_split;
	logic [MEM_AW-1:0]   access_addr;
	logic [MEM_AW-1:0]   banked_addr;
	logic [MEM_AW-1:0]   indexed_addr;
	logic [MEM_AW-1:0]   operand_addr;
	logic                in_q3;
	logic                in_q4;
	logic                clear_watchdog_op;
	logic                complement_register_op;
	logic                zero_register_op;
	logic                core_mem_we;
	logic                core_work_we;
	logic                flag_update;
	logic                wr_ctrl;
	logic                wr_bank;
	logic                wr_work;
	logic                wr_status;
	logic                wr_idx_lo;
	logic                wr_idx_hi;
	logic                wr_madr_lo;
	logic                wr_madr_hi;
	logic                wr_mdata;

	// instruction decode
	assign clear_watchdog_op = (instr_reg == CLEAR_WATCHDOG_WORD);
	assign complement_register_op =
		(instr_reg[INSTR_W-1:COMPLEMENT_PFX_LSB] == COMPLEMENT_PREFIX);
	assign zero_register_op = (instr_reg[INSTR_W-1:ZERO_PFX_LSB] == ZERO_PREFIX);
	assign op = clear_watchdog_op      ? CWC_OP_DOG  :
	            complement_register_op ? CWC_OP_COMP :
	            zero_register_op       ? CWC_OP_ZERO : CWC_OP_NONE;
	assign operand  = instr_reg[7:0];
	assign bank_bit = instr_reg[BANK_BIT];
	assign dest_bit = instr_reg[DEST_BIT];

	// operand address resolution
	assign indexed = !bank_bit && ext_en_reg && (operand <= INDEX_LIMIT);
	assign access_split = ext_en_reg ? ACCESS_SPLIT_EXT : ACCESS_SPLIT_STD;
	assign access_addr = {(operand < access_split) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK,
		operand};
	assign banked_addr = {bank_select_reg, operand};
	assign indexed_addr = index_reg + {4'h0, operand};
	assign operand_addr = bank_bit ? banked_addr :
	                      indexed  ? indexed_addr : access_addr;

	assign in_q3 = (phase_reg == CWC_Q3);
	assign in_q4 = (phase_reg == CWC_Q4);
	assign core_mem_we = in_q4 && ((op == CWC_OP_ZERO) ||
		((op == CWC_OP_COMP) && dest_bit));
	assign core_work_we = in_q4 && (op == CWC_OP_COMP) && !dest_bit;
	assign flag_update = in_q4 && ((op == CWC_OP_COMP) || (op == CWC_OP_ZERO));

	assign mem_bus.a_addr  = operand_addr;
	assign mem_bus.a_wdata = result_reg;
	assign mem_bus.a_we    = core_mem_we;
	assign mem_bus.b_addr  = mem_addr_reg;
	assign mem_bus.b_wdata = bus_wdata_i;
	assign mem_bus.b_we    = wr_mdata;

	// register port write decode
	assign wr_ctrl    = bus_wr_i && (bus_addr_i == REG_CTRL);
	assign wr_bank    = bus_wr_i && (bus_addr_i == REG_BANK);
	assign wr_work    = bus_wr_i && (bus_addr_i == REG_WORK);
	assign wr_status  = bus_wr_i && (bus_addr_i == REG_STATUS);
	assign wr_idx_lo  = bus_wr_i && (bus_addr_i == REG_INDEX_LO);
	assign wr_idx_hi  = bus_wr_i && (bus_addr_i == REG_INDEX_HI);
	assign wr_madr_lo = bus_wr_i && (bus_addr_i == REG_MEM_ADDR_LO);
	assign wr_madr_hi = bus_wr_i && (bus_addr_i == REG_MEM_ADDR_HI);
	assign wr_mdata   = bus_wr_i && (bus_addr_i == REG_MEM_DATA);

	// four-phase instruction cycle
	always_comb begin
		case (phase_reg)
			CWC_Q1:  phase_next = CWC_Q2;
			CWC_Q2:  phase_next = CWC_Q3;
			CWC_Q3:  phase_next = CWC_Q4;
			default: phase_next = CWC_Q1;
		endcase
	end

	// a fresh word is taken in Q1, otherwise the slot executes as no-op
	assign instr_next = (phase_reg != CWC_Q1) ? instr_reg :
	                    instr_valid_i ? instr_word_i : {INSTR_W{1'b0}};

	assign result_next = !in_q3 ? result_reg :
	                     (op == CWC_OP_COMP) ? ~mem_bus.a_rdata : BYTE_ZERO;

	assign work_next = core_work_we ? result_reg :
	                   wr_work ? bus_wdata_i : work_reg;

	// hardware updates come last so a set wins over a software clear
	always_comb begin
		status_next = wr_status ? bus_wdata_i[STATUS_W-1:0] : status_reg;
		if (in_q3 && (op == CWC_OP_DOG)) begin
			status_next[ST_TIMEOUT] = 1'b1;
			status_next[ST_POWERDOWN] = 1'b1;
		end
		if (flag_update) begin
			status_next[ST_ZERO] = (result_reg == BYTE_ZERO);
			if (op == CWC_OP_COMP) begin
				status_next[ST_NEG] = result_reg[DATA_W-1];
			end
		end
	end

	// register port read mux
	always_comb begin
		rdata_next = BYTE_ZERO;
		if (!bus_rd_i) begin
			rdata_next = BYTE_ZERO;
		end else if (bus_addr_i == REG_CTRL) begin
			rdata_next = {7'h00, ext_en_reg};
		end else if (bus_addr_i == REG_BANK) begin
			rdata_next = {4'h0, bank_select_reg};
		end else if (bus_addr_i == REG_WORK) begin
			rdata_next = work_reg;
		end else if (bus_addr_i == REG_STATUS) begin
			rdata_next = {4'h0, status_reg};
		end else if (bus_addr_i == REG_INDEX_LO) begin
			rdata_next = index_reg[7:0];
		end else if (bus_addr_i == REG_INDEX_HI) begin
			rdata_next = {4'h0, index_reg[MEM_AW-1:8]};
		end else if (bus_addr_i == REG_MEM_ADDR_LO) begin
			rdata_next = mem_addr_reg[7:0];
		end else if (bus_addr_i == REG_MEM_ADDR_HI) begin
			rdata_next = {4'h0, mem_addr_reg[MEM_AW-1:8]};
		end else if (bus_addr_i == REG_MEM_DATA) begin
			rdata_next = mem_bus.b_rdata;
		end else if (bus_addr_i == REG_CLEAR_COUNT) begin
			rdata_next = watchdog_clears_reg;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_reg  <= CWC_Q1;
			instr_reg  <= {INSTR_W{1'b0}};
			result_reg <= BYTE_ZERO;
			work_reg   <= BYTE_ZERO;
			status_reg <= STATUS_RST;
			rdata_reg  <= BYTE_ZERO;
		end else begin
			phase_reg  <= phase_next;
			instr_reg  <= instr_next;
			result_reg <= result_next;
			work_reg   <= work_next;
			status_reg <= status_next;
			rdata_reg  <= rdata_next;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_en_reg      <= 1'b0;
			bank_select_reg <= BANK_RST;
			index_reg       <= ADDR_ZERO;
			mem_addr_reg    <= ADDR_ZERO;
		end else begin
			if (wr_ctrl) ext_en_reg <= bus_wdata_i[CTRL_EXT_BIT];
			if (wr_bank) bank_select_reg <= bus_wdata_i[3:0];
			if (wr_idx_lo) index_reg[7:0] <= bus_wdata_i;
			if (wr_idx_hi) index_reg[MEM_AW-1:8] <= bus_wdata_i[3:0];
			if (wr_madr_lo) mem_addr_reg[7:0] <= bus_wdata_i;
			if (wr_madr_hi) mem_addr_reg[MEM_AW-1:8] <= bus_wdata_i[3:0];
		end
	end

	// watchdog clear pulse for counter and postscaler
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dog_clear_reg       <= 1'b0;
			watchdog_clears_reg <= BYTE_ZERO;
		end else begin
			dog_clear_reg <= in_q3 && (op == CWC_OP_DOG);
			if (in_q3 && (op == CWC_OP_DOG)) begin
				watchdog_clears_reg <= watchdog_clears_reg + 8'h01;
			end
		end
	end

	assign bus_rdata_o      = rdata_reg;
	assign phase_o          = phase_reg;
	assign watchdog_clear_o = dog_clear_reg;
	assign timeout_flag_o   = status_reg[ST_TIMEOUT];
	assign powerdown_flag_o = status_reg[ST_POWERDOWN];
	assign work_reg_o       = work_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence watchdog_taken_s;
		(phase_reg == CWC_Q1) && instr_valid_i && (instr_word_i == CLEAR_WATCHDOG_WORD);
	endsequence

	sequence zero_taken_s;
		(phase_reg == CWC_Q1) && instr_valid_i &&
		(instr_word_i[INSTR_W-1:ZERO_PFX_LSB] == ZERO_PREFIX);
	endsequence

	watchdog_pulse_a: assert property (
		watchdog_taken_s |-> ##3 (watchdog_clear_o && timeout_flag_o && powerdown_flag_o)
		##1 !watchdog_clear_o)
		else $error("watchdog clear pulse or flags missing");

	other_flags_kept_a: assert property (
		(in_q3 && (op == CWC_OP_DOG) && !wr_status) |=>
		(status_reg[ST_ZERO] == $past(status_reg[ST_ZERO])) &&
		(status_reg[ST_NEG] == $past(status_reg[ST_NEG])))
		else $error("clear watchdog disturbed other flags");

	comp_inverse_a: assert property (
		(in_q3 && (op == CWC_OP_COMP)) |=> (result_reg == ~$past(mem_bus.a_rdata)))
		else $error("complement result is not the inverse");

	comp_to_work_a: assert property (
		(in_q4 && (op == CWC_OP_COMP) && !dest_bit) |->
		!mem_bus.a_we ##1 (work_reg == $past(result_reg)))
		else $error("complement to working register failed");

	comp_to_file_a: assert property (
		(in_q4 && (op == CWC_OP_COMP) && dest_bit) |->
		mem_bus.a_we && (mem_bus.a_wdata == ~$past(mem_bus.a_rdata))
		##1 ($stable(work_reg) || $past(wr_work)))
		else $error("complement write-back failed");

	bank_select_a: assert property (
		((phase_reg == CWC_Q2) && (op != CWC_OP_NONE) && bank_bit) |->
		(mem_bus.a_addr[MEM_AW-1:8] == bank_select_reg))
		else $error("banked operand not from bank select register");

	access_bank_a: assert property (
		((phase_reg == CWC_Q2) && !bank_bit && !ext_en_reg) |->
		(mem_bus.a_addr[MEM_AW-1:8] == (operand[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK)))
		else $error("access bank address wrong");

	indexed_mode_a: assert property (
		((phase_reg == CWC_Q2) && !bank_bit && ext_en_reg && (operand <= INDEX_LIMIT)) |->
		(mem_bus.a_addr == index_reg + {4'h0, operand}))
		else $error("indexed literal offset address wrong");

	zero_write_a: assert property (
		zero_taken_s |-> ##3 (mem_bus.a_we && (mem_bus.a_wdata == BYTE_ZERO)))
		else $error("zero register write missing");

endmodule : cwc_exec
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the clear-watchdog and complement execute block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cwc_pkg::*;

	// rows: extended set, bank bit, operand, resolved address
	localparam logic [6:0][21:0] ROWS = {22'h010010, 22'h085F85, 22'h05F05F,
		22'h25F35F, 22'h200300, 22'h260F60, 22'h320220};

	logic               clk_i;
	logic               reset_n_i;
	logic [INSTR_W-1:0] instr_word_i;
	logic               instr_valid_i;
	logic [BUS_AW-1:0]  bus_addr_i;
	logic [DATA_W-1:0]  bus_wdata_i;
	logic               bus_wr_i;
	logic               bus_rd_i;
	logic [DATA_W-1:0]  bus_rdata_o;
	logic [1:0]         phase_o;
	logic               watchdog_clear_o;
	logic               timeout_flag_o;
	logic               powerdown_flag_o;
	logic [DATA_W-1:0]  work_reg_o;
	int                 errors;
	int                 checked;
	int                 pulses;
	logic [DATA_W-1:0]  rd;
	logic [21:0]        row;

	cwc_exec u_dut (
		.clk_i            (clk_i),
		.reset_n_i        (reset_n_i),
		.instr_word_i     (instr_word_i),
		.instr_valid_i    (instr_valid_i),
		.bus_addr_i       (bus_addr_i),
		.bus_wdata_i      (bus_wdata_i),
		.bus_wr_i         (bus_wr_i),
		.bus_rd_i         (bus_rd_i),
		.bus_rdata_o      (bus_rdata_o),
		.phase_o          (phase_o),
		.watchdog_clear_o (watchdog_clear_o),
		.timeout_flag_o   (timeout_flag_o),
		.powerdown_flag_o (powerdown_flag_o),
		.work_reg_o       (work_reg_o)
	);

	always #10 clk_i = ~clk_i;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	// each bus task starts and ends just after a rising edge, strobe then idle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus_addr_i  <= a;
		bus_wdata_i <= d;
		bus_wr_i    <= 1'b1;
		@(posedge clk_i);
		bus_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr

	task automatic expect_reg(input logic [3:0] a, input logic [7:0] e);
		bus_addr_i <= a;
		bus_rd_i   <= 1'b1;
		@(posedge clk_i);
		bus_rd_i <= 1'b0;
		@(posedge clk_i);
		rd = bus_rdata_o;
		chk(rd, e);
	endtask : expect_reg

	task automatic set_addr(input logic [11:0] a);
		wr(REG_MEM_ADDR_LO, a[7:0]);
		wr(REG_MEM_ADDR_HI, {4'h0, a[11:8]});
	endtask : set_addr

	task automatic poke(input logic [11:0] a, input logic [7:0] d);
		set_addr(a);
		wr(REG_MEM_DATA, d);
	endtask : poke

	task automatic peek(input logic [11:0] a, input logic [7:0] e);
		set_addr(a);
		expect_reg(REG_MEM_DATA, e);
	endtask : peek

	// issue one word in the next Q1 slot, return once the cycle has retired
	task automatic exec(input logic [15:0] w);
		int i;
		for (i = 0; i < 8; i++) begin
			@(posedge clk_i);
			if (phase_o == CWC_Q4) break;
		end
		if (i == 8) begin
			errors++;
			wrap_up();
		end
		instr_word_i  <= w;
		instr_valid_i <= 1'b1;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : exec

	always @(posedge clk_i) begin
		if (watchdog_clear_o === 1'b1) begin
			pulses++;
			chk(8'(phase_o), 8'h03);
		end
	end

	initial begin
		clk_i = 1'b0;
		reset_n_i = 1'b0;
		instr_word_i = 16'h0000;
		instr_valid_i = 1'b0;
		bus_addr_i = 4'h0;
		bus_wdata_i = 8'h00;
		bus_wr_i = 1'b0;
		bus_rd_i = 1'b0;
		errors = 0;
		checked = 0;
		pulses = 0;
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		chk({6'h00, timeout_flag_o, powerdown_flag_o}, 8'h03);
		chk(work_reg_o, 8'h00);
		expect_reg(REG_STATUS, 8'h0C);
		wr(4'hF, 8'hAA);
		expect_reg(4'hF, 8'h00);
		wr(REG_CLEAR_COUNT, 8'h55);
		expect_reg(REG_CLEAR_COUNT, 8'h00);
		// clear flags by software so the instruction must set them again
		wr(REG_STATUS, 8'h03);
		chk({6'h00, timeout_flag_o, powerdown_flag_o}, 8'h00);
		exec(CLEAR_WATCHDOG_WORD);
		chk(8'(pulses), 8'h01);
		chk({6'h00, timeout_flag_o, powerdown_flag_o}, 8'h03);
		expect_reg(REG_STATUS, 8'h0F);
		expect_reg(REG_CLEAR_COUNT, 8'h01);
		exec(16'h0005);
		exec(16'h0104);
		exec(16'h8004);
		chk(8'(pulses), 8'h01);
		// complement through bank 2, written back and to the working register
		wr(REG_BANK, 8'h02);
		poke(12'h240, 8'h13);
		exec(16'h1F40);
		peek(12'h240, 8'hEC);
		chk(work_reg_o, 8'h00);
		expect_reg(REG_STATUS, 8'h0E);
		poke(12'h240, 8'h13);
		exec(16'h1D40);
		chk(work_reg_o, 8'hEC);
		peek(12'h240, 8'h13);
		poke(12'h240, 8'hFF);
		exec(16'h1F40);
		peek(12'h240, 8'h00);
		expect_reg(REG_STATUS, 8'h0D);
		// operand resolution across access bank, indexed offset and banked cases
		wr(REG_INDEX_LO, 8'h00);
		wr(REG_INDEX_HI, 8'h03);
		for (int k = 0; k < 7; k++) begin
			row = ROWS[k];
			wr(REG_CTRL, {7'h00, row[21]});
			poke(row[11:0], 8'h3C);
			exec({COMPLEMENT_PREFIX, 1'b1, row[20], row[19:12]});
			peek(row[11:0], 8'hC3);
		end
		wr(REG_CTRL, 8'h00);
		poke(12'h240, 8'h5A);
		exec(16'h6B40);
		peek(12'h240, 8'h00);
		expect_reg(REG_STATUS, 8'h0F);
		poke(12'h010, 8'hA5);
		exec(16'h6A10);
		peek(12'h010, 8'h00);
		peek(12'h240, 8'h00);
		// mid-run reset returns flags, working register, bank and count to reset state
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		chk(work_reg_o, 8'h00);
		expect_reg(REG_STATUS, 8'h0C);
		expect_reg(REG_BANK, 8'h00);
		expect_reg(REG_CLEAR_COUNT, 8'h00);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
